//--- logic/output_stop_pin_select.sv
// output-stop pin selection: select registers, code decode, per-pin stop drive
`timescale 1ns/1ns
// What this block does
// R1: select register holds A code in bits 3..0, B code in bits 7..4.
// R2: code zero means no pin is stopped for that timer output.
// R3: software writes only defined codes; others are undefined.
// R4: channel 2 A: 1 port7_pin3, 2 portd_pin3, 4 portb_pin6; 3 not in later.
// R5: earlier only, channel 2 A: 3 port1_pin4, 5 portk_pin0.
// R6: channel 2 B: 1 port7_pin6, 2 portd_pin2, 4 portb_pin5; 3 not in later.
// R7: earlier only, channel 2 B: 3 port1_pin7, 5 portk_pin1.
// R8: channel 3 A: 1 port3_pin2, 2 portd_pin1, 3 porte_pin5, 4 portd_pin7.
// R9: later only, channel 3 A: 5 portb_pin6, 6 port1_pin0.
// R10: channel 3 B: 1 port3_pin3, 2 portd_pin0, 3 port1_pin1, 4 portd_pin6.
// R11: later only, channel 3 B: 5 portb_pin5.
// R12: earlier, channel 7 A: 1 port9_pin5, 2 port1_pin2 only.
// R13: later, channel 7 A: 1 port9_pin5, 2 portb_pin2, 3 port3_pin2, 4 portd_pin5.
// R14: earlier, channel 7 B: 1 port9_pin2, 2 port1_pin5 only.
// R15: later, channel 7 B: 1 port9_pin2, 2 portb_pin1, 3 port3_pin3, 4 portd_pin3.
// R16: channel 8 and 9 select registers exist only in the earlier variant.
// R17: software muxes the timer output onto the chosen pin; not checked here.
module output_stop_pin_select #(
  parameter bit later_variant = 1'b1
) (
  input wire logic clk, // 50 MHz clock
  input wire logic rst, // sync reset, high
  input wire logic ce, // clock enable
  input wire logic [4:0] addr, // register byte address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  output logic [31:0] rd_data, // read data, cycle after rd_stb
  input wire logic [5:0] stop_req, // stop request per timer output
  output logic [25:0] pin_stop // stop drive per port pin
);
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;
  logic [25:0] pin_stop_q;
  logic [25:0] pin_stop_d;
  logic [5:0] bad_q;
  logic [5:0] bad_d;
  logic [5:0] bad_set;
  logic [5:0] code_ok;
  logic [3:0] codes [0:5];
  logic [25:0] field_pins [0:5];

  sel_regs_if regs ();

  sel_reg_bank #(
    .later_variant(later_variant)
  ) u_bank (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .regs(regs.bank)
  );

  function automatic logic [25:0] one_pin(input int unsigned idx);
    logic [25:0] one;
    one = 26'h0000001;
    return one << idx;
  endfunction

  // pin selected by one code; zero for code 0 and forbidden codes
  function automatic logic [25:0] pin_of(input int unsigned f, input logic [3:0] code, input bit later);
    logic [25:0] p;
    p = '0;
    if (code != stop_sel_pkg::code_off) begin // R2
      case (f)
        stop_sel_pkg::f_pwm2_a: begin
          case (code)
            stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port7_pin3); // R4
            stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::portd_pin3); // R4
            stop_sel_pkg::code_4: p = one_pin(stop_sel_pkg::portb_pin6); // R4
            stop_sel_pkg::code_3: p = later ? '0 : one_pin(stop_sel_pkg::port1_pin4); // R5
            stop_sel_pkg::code_5: p = later ? '0 : one_pin(stop_sel_pkg::portk_pin0); // R5
            default: p = '0;
          endcase
        end
        stop_sel_pkg::f_pwm2_b: begin
          case (code)
            stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port7_pin6); // R6
            stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::portd_pin2); // R6
            stop_sel_pkg::code_4: p = one_pin(stop_sel_pkg::portb_pin5); // R6
            stop_sel_pkg::code_3: p = later ? '0 : one_pin(stop_sel_pkg::port1_pin7); // R7
            stop_sel_pkg::code_5: p = later ? '0 : one_pin(stop_sel_pkg::portk_pin1); // R7
            default: p = '0;
          endcase
        end
        stop_sel_pkg::f_pwm3_a: begin
          case (code)
            stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port3_pin2); // R8
            stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::portd_pin1); // R8
            stop_sel_pkg::code_3: p = one_pin(stop_sel_pkg::porte_pin5); // R8
            stop_sel_pkg::code_4: p = one_pin(stop_sel_pkg::portd_pin7); // R8
            stop_sel_pkg::code_5: p = later ? one_pin(stop_sel_pkg::portb_pin6) : '0; // R9
            stop_sel_pkg::code_6: p = later ? one_pin(stop_sel_pkg::port1_pin0) : '0; // R9
            default: p = '0;
          endcase
        end
        stop_sel_pkg::f_pwm3_b: begin
          case (code)
            stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port3_pin3); // R10
            stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::portd_pin0); // R10
            stop_sel_pkg::code_3: p = one_pin(stop_sel_pkg::port1_pin1); // R10
            stop_sel_pkg::code_4: p = one_pin(stop_sel_pkg::portd_pin6); // R10
            stop_sel_pkg::code_5: p = later ? one_pin(stop_sel_pkg::portb_pin5) : '0; // R11
            default: p = '0;
          endcase
        end
        stop_sel_pkg::f_pwm7_a: begin
          if (later) begin
            case (code)
              stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port9_pin5); // R13
              stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::portb_pin2); // R13
              stop_sel_pkg::code_3: p = one_pin(stop_sel_pkg::port3_pin2); // R13
              stop_sel_pkg::code_4: p = one_pin(stop_sel_pkg::portd_pin5); // R13
              default: p = '0;
            endcase
          end else begin
            case (code)
              stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port9_pin5); // R12
              stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::port1_pin2); // R12
              default: p = '0;
            endcase
          end
        end
        stop_sel_pkg::f_pwm7_b: begin
          if (later) begin
            case (code)
              stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port9_pin2); // R15
              stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::portb_pin1); // R15
              stop_sel_pkg::code_3: p = one_pin(stop_sel_pkg::port3_pin3); // R15
              stop_sel_pkg::code_4: p = one_pin(stop_sel_pkg::portd_pin3); // R15
              default: p = '0;
            endcase
          end else begin
            case (code)
              stop_sel_pkg::code_1: p = one_pin(stop_sel_pkg::port9_pin2); // R14
              stop_sel_pkg::code_2: p = one_pin(stop_sel_pkg::port1_pin5); // R14
              default: p = '0;
            endcase
          end
        end
        default: p = '0;
      endcase
    end
    return p;
  endfunction

  // a code is acceptable when it is zero or names a pin
  function automatic logic code_legal(input int unsigned f, input logic [3:0] code, input bit later);
    return (code == stop_sel_pkg::code_off) || (|pin_of(f, code, later));
  endfunction

  // field split of the three decoded registers
  always_comb begin
    for (int r = 0; r < 3; r++) begin
      codes[2 * r] = regs.sel[r][stop_sel_pkg::a_lsb +: stop_sel_pkg::code_w]; // R1
      codes[2 * r + 1] = regs.sel[r][stop_sel_pkg::b_lsb +: stop_sel_pkg::code_w]; // R1
    end
  end

  always_comb begin
    for (int f = 0; f < 6; f++) begin
      field_pins[f] = pin_of(f, codes[f], later_variant);
      code_ok[f] = code_legal(f, codes[f], later_variant);
    end
  end

  // register write path into the bank
  always_comb begin
    regs.wr_en = wr_stb && (addr[1:0] == 2'h0) && (addr <= stop_sel_pkg::off_pwm9_sel);
    regs.wr_idx = addr[4:2];
    regs.wr_byte = wr_data[7:0];
  end

  // forbidden code written: flagged, the value is still stored
  always_comb begin
    bad_set = '0;
    if (wr_stb && addr[1:0] == 2'h0 && addr < stop_sel_pkg::off_pwm8_sel) begin // R3
      bad_set[2 * addr[3:2]] = !code_legal(2 * addr[3:2], wr_data[3:0], later_variant);
      bad_set[2 * addr[3:2] + 1] = !code_legal(2 * addr[3:2] + 1, wr_data[7:4], later_variant);
    end
  end

  // write one to clear; a new flag in the same cycle wins
  always_comb begin
    bad_d = bad_q;
    if (wr_stb && addr == stop_sel_pkg::off_bad_code) begin
      bad_d = bad_q & ~wr_data[5:0];
    end
    bad_d = bad_d | bad_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bad_q <= stop_sel_pkg::bad_reset;
    end else if (ce) begin
      bad_q <= bad_d;
    end
  end

  // stop drive goes only to the pin the code names
  always_comb begin
    pin_stop_d = '0;
    for (int f = 0; f < 6; f++) begin
      if (stop_req[f]) begin
        pin_stop_d = pin_stop_d | field_pins[f]; // R2
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_stop_q <= stop_sel_pkg::pin_reset;
    end else if (ce) begin
      pin_stop_q <= pin_stop_d;
    end
  end

  // read mux; data stand only in the cycle after the strobe
  always_comb begin
    rd_data_d = '0;
    if (rd_stb) begin
      case (addr)
        stop_sel_pkg::off_pwm2_sel: rd_data_d = {24'h000000, regs.sel[0]};
        stop_sel_pkg::off_pwm3_sel: rd_data_d = {24'h000000, regs.sel[1]};
        stop_sel_pkg::off_pwm7_sel: rd_data_d = {24'h000000, regs.sel[2]};
        stop_sel_pkg::off_pwm8_sel: rd_data_d = later_variant ? '0 : {24'h000000, regs.sel[3]}; // R16
        stop_sel_pkg::off_pwm9_sel: rd_data_d = later_variant ? '0 : {24'h000000, regs.sel[4]}; // R16
        stop_sel_pkg::off_code_ok: rd_data_d = {26'h0000000, code_ok};
        stop_sel_pkg::off_bad_code: rd_data_d = {26'h0000000, bad_q};
        stop_sel_pkg::off_pin_stop: rd_data_d = {6'h00, pin_stop_q};
        default: rd_data_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_data_q <= '0;
    end else if (ce) begin
      rd_data_q <= rd_data_d;
    end
  end

  assign rd_data = rd_data_q;
  assign pin_stop = pin_stop_q;
endmodule

//--- logic/stop_sel_pkg.sv
// constants for the output-stop pin selection block
package stop_sel_pkg;
  localparam int unsigned addr_w = 5;
  localparam int unsigned data_w = 32;
  localparam int unsigned reg_w = 8;
  localparam int unsigned code_w = 4;
  localparam int unsigned pin_n = 26;
  localparam int unsigned field_n = 6;
  localparam int unsigned sel_n = 5;
  // byte offsets
  localparam logic [4:0] off_pwm2_sel = 5'h00;
  localparam logic [4:0] off_pwm3_sel = 5'h04;
  localparam logic [4:0] off_pwm7_sel = 5'h08;
  localparam logic [4:0] off_pwm8_sel = 5'h0c;
  localparam logic [4:0] off_pwm9_sel = 5'h10;
  localparam logic [4:0] off_code_ok = 5'h14;
  localparam logic [4:0] off_bad_code = 5'h18;
  localparam logic [4:0] off_pin_stop = 5'h1c;
  // field positions inside a select register
  localparam int unsigned a_lsb = 0;
  localparam int unsigned b_lsb = 4;
  // reset values
  localparam logic [7:0] sel_reset = 8'h00;
  localparam logic [5:0] bad_reset = 6'h00;
  localparam logic [25:0] pin_reset = 26'h0000000;
  // timer output order: 2a 2b 3a 3b 7a 7b
  localparam int unsigned f_pwm2_a = 0;
  localparam int unsigned f_pwm2_b = 1;
  localparam int unsigned f_pwm3_a = 2;
  localparam int unsigned f_pwm3_b = 3;
  localparam int unsigned f_pwm7_a = 4;
  localparam int unsigned f_pwm7_b = 5;
  // codes
  localparam logic [3:0] code_off = 4'h0;
  localparam logic [3:0] code_1 = 4'h1;
  localparam logic [3:0] code_2 = 4'h2;
  localparam logic [3:0] code_3 = 4'h3;
  localparam logic [3:0] code_4 = 4'h4;
  localparam logic [3:0] code_5 = 4'h5;
  localparam logic [3:0] code_6 = 4'h6;
  // bit positions of pin_stop
  localparam int unsigned port7_pin3 = 0;
  localparam int unsigned portd_pin3 = 1;
  localparam int unsigned port1_pin4 = 2;
  localparam int unsigned portb_pin6 = 3;
  localparam int unsigned portk_pin0 = 4;
  localparam int unsigned port7_pin6 = 5;
  localparam int unsigned portd_pin2 = 6;
  localparam int unsigned port1_pin7 = 7;
  localparam int unsigned portb_pin5 = 8;
  localparam int unsigned portk_pin1 = 9;
  localparam int unsigned port3_pin2 = 10;
  localparam int unsigned portd_pin1 = 11;
  localparam int unsigned porte_pin5 = 12;
  localparam int unsigned portd_pin7 = 13;
  localparam int unsigned port1_pin0 = 14;
  localparam int unsigned port3_pin3 = 15;
  localparam int unsigned portd_pin0 = 16;
  localparam int unsigned port1_pin1 = 17;
  localparam int unsigned portd_pin6 = 18;
  localparam int unsigned port9_pin5 = 19;
  localparam int unsigned port1_pin2 = 20;
  localparam int unsigned portb_pin2 = 21;
  localparam int unsigned portd_pin5 = 22;
  localparam int unsigned port9_pin2 = 23;
  localparam int unsigned port1_pin5 = 24;
  localparam int unsigned portb_pin1 = 25;
endpackage

//--- logic/sel_regs_if.sv
// write path and contents of the select register bank
`timescale 1ns/1ns
interface sel_regs_if;
  logic wr_en;
  logic [2:0] wr_idx;
  logic [7:0] wr_byte;
  logic [7:0] sel [0:4];
  modport bank (input wr_en, input wr_idx, input wr_byte, output sel);
  modport user (output wr_en, output wr_idx, output wr_byte, input sel);
endinterface

//--- logic/sel_reg_bank.sv
// storage for the five pin select registers
`timescale 1ns/1ns
module sel_reg_bank #(
  parameter bit later_variant = 1'b1
) (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  sel_regs_if.bank regs // write port and contents
);
  logic [7:0] sel_q [0:4];

  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < 5; i++) begin
        sel_q[i] <= stop_sel_pkg::sel_reset;
      end
    end else if (ce && regs.wr_en) begin
      // channels 8 and 9 exist only in the earlier variant
      if (regs.wr_idx < 3'h3 || (!later_variant && regs.wr_idx < 3'h5)) begin // R16
        sel_q[regs.wr_idx] <= regs.wr_byte;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < 5; i++) begin
      regs.sel[i] = sel_q[i];
    end
  end
endmodule

//--- test/stop_sel_props.sv
// concurrent checks on the pin selection block ports
`timescale 1ns/1ns
module stop_sel_props #(
  parameter bit later_variant = 1'b1
) (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic [4:0] addr, // byte address
  input wire logic [31:0] wr_data, // write data
  input wire logic wr_stb, // write strobe
  input wire logic rd_stb, // read strobe
  input wire logic [31:0] rd_data, // read data
  input wire logic [5:0] stop_req, // stop requests
  input wire logic [25:0] pin_stop // pin stop drive
);
  logic [7:0] sh_q [0:2];
  // shadow of the three select registers
  always_ff @(posedge clk) begin
    for (int i = 0; i < 3; i++) begin
      if (rst && ce) begin
        sh_q[i] <= 8'h00;
      end else if (ce && wr_stb && addr == 5'(i * 4)) begin
        sh_q[i] <= wr_data[7:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_read_idle_zero: assert property ((ce && !rd_stb) |=> rd_data == 32'h0)
    else $error("read data not zero outside a read answer");
  a_sel_readback: assert property ((ce && rd_stb && addr == stop_sel_pkg::off_pwm3_sel)
    |=> rd_data == {24'h0, $past(sh_q[1])}) else $error("select register readback wrong");
  a_no_req_quiet: assert property ((ce && stop_req == 6'h00) |=> pin_stop == 26'h0)
    else $error("pin stopped without request");
  a_zero_code: assert property ((ce && sh_q[0][3:0] == 4'h0 && stop_req == 6'h01) |=> pin_stop == 26'h0)
    else $error("code zero still stops a pin");
  a_ch2a_map: assert property ((ce && sh_q[0][3:0] == 4'h1 && stop_req[0])
    |=> pin_stop[stop_sel_pkg::port7_pin3]) else $error("channel 2 A code 1 pin missing");
  a_ch2a_forbid: assert property ((later_variant && ce && sh_q[0][3:0] == 4'h3 && stop_req == 6'h01)
    |=> pin_stop == 26'h0) else $error("forbidden code drives a pin");
  a_ch2a_early: assert property ((!later_variant && ce && sh_q[0][3:0] == 4'h5 && stop_req[0])
    |=> pin_stop[stop_sel_pkg::portk_pin0]) else $error("channel 2 A code 5 pin missing");
  a_ch7a_early: assert property ((!later_variant && ce && sh_q[2][3:0] == 4'h2 && stop_req[4])
    |=> pin_stop[stop_sel_pkg::port1_pin2]) else $error("channel 7 A code 2 pin missing");
  a_ch3a_late: assert property ((later_variant && ce && sh_q[1][3:0] == 4'h6 && stop_req[2])
    |=> pin_stop[stop_sel_pkg::port1_pin0]) else $error("channel 3 A code 6 pin missing");
  a_ch3b_late: assert property ((later_variant && ce && sh_q[1][7:4] == 4'h5 && stop_req == 6'h08)
    |=> pin_stop == 26'h1 << stop_sel_pkg::portb_pin5) else $error("channel 3 B code 5 wrong");
  a_ch7b_late: assert property ((later_variant && ce && sh_q[2][7:4] == 4'h4 && stop_req[5])
    |=> pin_stop[stop_sel_pkg::portd_pin3]) else $error("channel 7 B code 4 pin missing");
  a_no_ch9_late: assert property ((later_variant && ce && rd_stb && addr == stop_sel_pkg::off_pwm9_sel)
    |=> rd_data == 32'h0) else $error("absent register reads nonzero");
  c_pin_read: cover property (ce && rd_stb && addr == stop_sel_pkg::off_pin_stop);
  c_stop_seen: cover property (stop_req != 6'h00 ##1 pin_stop != 26'h0);
  c_flag_clear: cover property (ce && wr_stb && addr == stop_sel_pkg::off_bad_code);
endmodule
bind output_stop_pin_select stop_sel_props #(.later_variant(later_variant)) i_props (.clk(clk), .rst(rst),
  .ce(ce), .addr(addr), .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data),
  .stop_req(stop_req), .pin_stop(pin_stop));

//--- test/pwm_out_model.sv
// timer outputs that raise output-stop requests
`timescale 1ns/1ns
module pwm_out_model (
  input wire logic clk, // clock
  input wire logic rst, // sync reset
  input wire logic [5:0] fault, // outputs told to request
  output logic [5:0] stop_req // level request per output
);
  always_ff @(posedge clk) begin
    if (rst) begin
      stop_req <= 6'h00;
    end else begin
      stop_req <= fault;
    end
  end
endmodule

//--- test/tb.sv
// self-checking bench for the pin selection block
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [4:0] addr = 5'h00;
  logic [31:0] wr_data = 32'h0;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic [31:0] rd_data;
  logic [31:0] rd_data_e;
  logic [5:0] stop_req;
  logic [5:0] fault = 6'h00;
  logic [25:0] pin_stop;
  logic [25:0] pin_stop_e;
  logic rd_due = 1'b0;
  logic [63:0] exp_q [$];
  logic [63:0] ev;
  logic [31:0] v;
  logic [7:0] sel [3] = '{8'h00, 8'h00, 8'h00};
  int err_count = 0;
  int checks = 0;
  int seed = 14;
  // pin bit per output for codes 1..6, -1 for none; [0] later, [1] earlier variant
  int map [2][6][6] = '{'{'{0, 1, -1, 3, -1, -1}, '{5, 6, -1, 8, -1, -1}, '{10, 11, 12, 13, 3, 14},
    '{15, 16, 17, 18, 8, -1}, '{19, 21, 10, 22, -1, -1}, '{23, 25, 15, 1, -1, -1}},
    '{'{0, 1, 2, 3, 4, -1}, '{5, 6, 7, 8, 9, -1}, '{10, 11, 12, 13, -1, -1},
    '{15, 16, 17, 18, -1, -1}, '{19, 20, -1, -1, -1, -1}, '{23, 24, -1, -1, -1, -1}}};
  always #10 clk = ~clk;
  output_stop_pin_select i_dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wr_data(wr_data),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data), .stop_req(stop_req), .pin_stop(pin_stop));
  output_stop_pin_select #(.later_variant(1'b0)) i_dut_early (.clk(clk), .rst(rst), .ce(ce), .addr(addr),
    .wr_data(wr_data), .wr_stb(wr_stb), .rd_stb(rd_stb), .rd_data(rd_data_e), .stop_req(stop_req),
    .pin_stop(pin_stop_e));
  pwm_out_model i_pins (.clk(clk), .rst(rst), .fault(fault), .stop_req(stop_req));
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [25:0] want_pins(logic [5:0] req, int e);
    logic [25:0] m;
    logic [3:0] c;
    m = 26'h0;
    for (int f = 0; f < 6; f++) begin
      c = sel[f / 2][(f % 2) * 4 +: 4];
      if (req[f] && c >= 4'h1 && c <= 4'h6 && map[e][f][c - 1] >= 0) m[map[e][f][c - 1]] = 1'b1;
    end
    return m;
  endfunction
  task automatic wr(logic [4:0] a, logic [31:0] d);
    @(posedge clk);
    wr_stb <= 1'b1;
    addr <= a;
    wr_data <= d;
    if (a <= 5'h08 && a[1:0] == 2'b00) sel[a[3:2]] = d[7:0];
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(logic [4:0] a, logic [31:0] e, logic [31:0] ee);
    @(posedge clk);
    rd_stb <= 1'b1;
    addr <= a;
    exp_q.push_back({ee, e});
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask
  task automatic apply(logic [5:0] r);
    @(posedge clk);
    fault <= r;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pin_stop", {6'h0, pin_stop}, {6'h0, want_pins(r, 0)});
    chk("pin_stop_early", {6'h0, pin_stop_e}, {6'h0, want_pins(r, 1)});
  endtask
  // read answers are compared in the cycle after the strobe
  always @(posedge clk) rd_due <= rd_stb;
  always @(negedge clk) begin
    if (rd_due) begin
      if (exp_q.size() == 0) chk("read queue", 32'h1, 32'h0);
      else begin
        ev = exp_q.pop_front();
        chk("rd_data", rd_data, ev[31:0]);
        chk("rd_data_early", rd_data_e, ev[63:32]);
      end
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    chk("watchdog", 32'h1, 32'h0);
    results();
  end
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) rd(5'(i * 4), i == 5 ? 32'h3f : 32'h0, i == 5 ? 32'h3f : 32'h0);
    for (int f = 0; f < 6; f++) begin
      for (int c = 0; c < 16; c++) begin
        wr(5'((f / 2) * 4), 32'hffffff00 | (32'(c) << ((f % 2) * 4)));
        rd(5'((f / 2) * 4), 32'(c) << ((f % 2) * 4), 32'(c) << ((f % 2) * 4));
        apply(6'h3f);
        apply(6'(1 << f));
      end
    end
    rd(stop_sel_pkg::off_bad_code, 32'h3f, 32'h3f);
    wr(stop_sel_pkg::off_bad_code, 32'h1);
    rd(stop_sel_pkg::off_bad_code, 32'h3e, 32'h3e);
    wr(stop_sel_pkg::off_code_ok, 32'h3f);
    rd(stop_sel_pkg::off_code_ok, 32'h15, 32'h15);
    wr(stop_sel_pkg::off_pwm8_sel, 32'h55);
    rd(stop_sel_pkg::off_pwm8_sel, 32'h0, 32'h55);
    for (int n = 0; n < 40; n++) begin
      for (int k = 0; k < 3; k++) begin
        v = $random(seed);
        wr(5'(k * 4), {25'h0, v[6:4], 1'b0, v[2:0]});
      end
      apply(v[13:8]);
      rd(stop_sel_pkg::off_pin_stop, {6'h0, want_pins(v[13:8], 0)}, {6'h0, want_pins(v[13:8], 1)});
    end
    // clock enable low: pin drive must stay frozen while requests change
    @(posedge clk);
    ce <= 1'b0;
    fault <= ~v[13:8];
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("pin_stop_hold", {6'h0, pin_stop}, {6'h0, want_pins(v[13:8], 0)});
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    sel = '{8'h00, 8'h00, 8'h00};
    rd(stop_sel_pkg::off_pwm7_sel, 32'h0, 32'h0);
    apply(6'h3f);
    repeat (2) @(posedge clk);
    results();
  end
endmodule
